// ### fsp_regs.svh
`ifndef FSP_REGS_SVH
`define FSP_REGS_SVH
// register byte addresses on the plain port
`define FSP_ADDR_CMD      8'h00
`define FSP_ADDR_STATUS   8'h01
`define FSP_ADDR_KEY      8'h02
`define FSP_ADDR_MODE     8'h03
`define FSP_ADDR_PROT     8'h04
`define FSP_ADDR_ADRL     8'h05
`define FSP_ADDR_ADRH     8'h06
`define FSP_ADDR_DATA     8'h07
`define FSP_ADDR_CFG      8'h08
`define FSP_ADDR_IMASK    8'h09
`define FSP_ADDR_ISTAT    8'h0A
`define FSP_ADDR_RDDATA   8'h0B
// values
`define FSP_KEY_VALUE     8'hA5
`define FSP_MODE_NORMAL   8'h00
`define FSP_MODE_SELF     8'h01
`define FSP_CMD_NONE      8'h00
`define FSP_CMD_WRITE     8'h01
`define FSP_CMD_ERASE     8'h02
`define FSP_RESET_BYTE    8'h00
`define FSP_ERASED_BYTE   8'hFF
// field positions, block width, capacity codes and limits, erase length
`define FSP_ST_SEQERR     0
`define FSP_ST_PROTERR    1
`define FSP_ST_DONE       2
`define FSP_IRQ_SEQERR    0
`define FSP_IRQ_PROTERR   1
`define FSP_IRQ_DONE      2
`define FSP_BLOCK_BITS    8
`define FSP_CAP_2K        2'h0
`define FSP_CAP_4K        2'h1
`define FSP_CAP_8K        2'h2
`define FSP_CAP_2K_BYTES  13'h0800
`define FSP_CAP_4K_BYTES  13'h1000
`define FSP_CAP_8K_LAST   13'h1FFF
`define FSP_ERASE_CYCLES  9'h100
`endif

// ### fsp_pkg.sv
package fsp_pkg;
  typedef enum logic [1:0] {
    FSP_SEQ_IDLE = 2'b00,
    FSP_SEQ_KEY  = 2'b01,
    FSP_SEQ_VAL  = 2'b10,
    FSP_SEQ_INV  = 2'b11
  } fsp_seq_e;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fsp_bus_s;
  typedef struct packed {
    logic        go;
    logic        erase;
    logic [12:0] addr;
    logic [7:0]  data;
  } fsp_op_s;
endpackage

// ### fsp_seq.sv
`timescale 1ns/10ps
`include "fsp_regs.svh"
module fsp_seq
  import fsp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire fsp_bus_s   bus,
  output logic            mode_self,
  output logic            seq_err,
  output logic            seq_done
);
  fsp_seq_e   st;
  logic [7:0] target;
  logic       mode_wr;
  logic       key_wr;
  assign mode_wr = bus.wr && bus.addr == `FSP_ADDR_MODE;
  assign key_wr  = bus.wr && bus.addr == `FSP_ADDR_KEY;

  // any write breaks the chain unless it is the next expected step
  always_ff @(posedge clk) begin
    seq_err  <= 1'b0;
    seq_done <= 1'b0;
    if (rst) begin
      st        <= FSP_SEQ_IDLE;
      target    <= `FSP_RESET_BYTE;
      mode_self <= 1'b1;
    end else if (bus.wr) begin
      unique case (st)
        FSP_SEQ_IDLE: begin
          if (key_wr && bus.wdata == `FSP_KEY_VALUE) begin
            st <= FSP_SEQ_KEY;
          end else if (key_wr || mode_wr) begin
            seq_err <= 1'b1;
          end
        end
        FSP_SEQ_KEY: begin
          if (mode_wr) begin
            target <= bus.wdata;
            st     <= FSP_SEQ_VAL;
          end else begin
            st      <= FSP_SEQ_IDLE;
            seq_err <= 1'b1;
          end
        end
        FSP_SEQ_VAL: begin
          if (mode_wr && bus.wdata == ~target) begin
            st <= FSP_SEQ_INV;
          end else begin
            st      <= FSP_SEQ_IDLE;
            seq_err <= 1'b1;
          end
        end
        FSP_SEQ_INV: begin
          st <= FSP_SEQ_IDLE;
          if (mode_wr && bus.wdata == target) begin
            mode_self <= target != `FSP_MODE_NORMAL;
            seq_done  <= 1'b1;
          end else begin
            seq_err <= 1'b1;
          end
        end
      endcase
    end
  end

  property p_bad_key;
    @(posedge clk) disable iff (rst)
      st == FSP_SEQ_IDLE && key_wr && bus.wdata != `FSP_KEY_VALUE
      |=> seq_err && $stable(mode_self);
  endproperty
  a_bad_key: assert property (p_bad_key)
    else $error("wrong key did not flag error");

  property p_done_mode;
    @(posedge clk) disable iff (rst)
      seq_done |-> mode_self == (target != `FSP_MODE_NORMAL);
  endproperty
  a_done_mode: assert property (p_done_mode)
    else $error("mode not taken from target");

  property p_first_discard;
    @(posedge clk) disable iff (rst)
      st == FSP_SEQ_KEY && mode_wr |=> $stable(mode_self) && !seq_done;
  endproperty
  a_first_discard: assert property (p_first_discard)
    else $error("first mode write took effect");

  property p_full_seq;
    @(posedge clk) disable iff (rst)
      (key_wr && bus.wdata == `FSP_KEY_VALUE && st == FSP_SEQ_IDLE)
      ##1 (mode_wr && bus.wdata == `FSP_MODE_NORMAL)
      ##1 (mode_wr && bus.wdata == ~`FSP_MODE_NORMAL)
      ##1 (mode_wr && bus.wdata == `FSP_MODE_NORMAL)
      |=> !mode_self && seq_done;
  endproperty
  a_full_seq: assert property (p_full_seq)
    else $error("good sequence did not enter normal mode");

  property p_err_stable;
    @(posedge clk) disable iff (rst) seq_err |-> $stable(mode_self);
  endproperty
  a_err_stable: assert property (p_err_stable)
    else $error("mode changed on failed sequence");

  c_done: cover property (@(posedge clk) disable iff (rst) seq_done);
  c_err: cover property (@(posedge clk) disable iff (rst) seq_err);
endmodule

// ### fsp_array.sv
`timescale 1ns/10ps
`include "fsp_regs.svh"
module fsp_array
  import fsp_pkg::*;
#(
  parameter int DEPTH = 8192
)(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire fsp_op_s     op,
  input  wire logic [12:0] rd_addr,
  output logic [7:0]       rd_data,
  output logic             busy
);
  localparam int BLK = 1 << `FSP_BLOCK_BITS;
  logic [7:0] mem [DEPTH];
  logic [`FSP_BLOCK_BITS-1:0] cnt;
  logic [12:0] base;
  logic        erasing;

  // erase walks the 256 bytes of one block, one per cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      erasing <= 1'b0;
      cnt     <= '0;
      base    <= '0;
    end else if (op.go && op.erase && !erasing) begin
      erasing <= 1'b1;
      cnt     <= '0;
      base    <= {op.addr[12:`FSP_BLOCK_BITS], `FSP_BLOCK_BITS'(0)};
    end else if (erasing) begin
      cnt <= cnt + 1'b1;
      if (cnt == `FSP_BLOCK_BITS'(BLK - 1)) begin
        erasing <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (erasing) begin
      mem[base | {5'h00, cnt}] <= `FSP_ERASED_BYTE;
    end else if (op.go && !op.erase) begin
      mem[op.addr] <= op.data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data <= `FSP_RESET_BYTE;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

  assign busy = erasing;
endmodule

// ### fsp_top.sv
`timescale 1ns/10ps
`include "fsp_regs.svh"
module fsp_top
  import fsp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic [7:0]      rdata,
  output logic            irq,
  output logic            self_mode
);
  fsp_bus_s    bus;
  fsp_op_s     op;
  logic [7:0]  cmd;
  logic [7:0]  prot;
  logic [12:0] fadr;
  logic [7:0]  fdata;
  logic [1:0]  cap;
  logic        st_seqerr;
  logic        st_proterr;
  logic        st_done;
  logic [2:0]  imask;
  logic [2:0]  istat;
  logic [2:0]  ev;
  logic        seq_err;
  logic        seq_done;
  logic        busy;
  logic [7:0]  arr_data;
  logic        cmd_wr;
  logic        allowed;
  logic        in_range;
  logic        op_ok;

  assign bus = '{wr: wr, rd: rd, addr: addr, wdata: wdata};

  fsp_seq u_seq (
    .clk       (clk),
    .rst       (rst),
    .bus       (bus),
    .mode_self (self_mode),
    .seq_err   (seq_err),
    .seq_done  (seq_done)
  );

  fsp_array #(.DEPTH(8192)) u_arr (
    .clk     (clk),
    .rst     (rst),
    .op      (op),
    .rd_addr (fadr),
    .rd_data (arr_data),
    .busy    (busy)
  );

  function automatic logic [12:0] cap_bytes(input logic [1:0] c);
    unique case (c)
      `FSP_CAP_2K: cap_bytes = `FSP_CAP_2K_BYTES;
      `FSP_CAP_4K: cap_bytes = `FSP_CAP_4K_BYTES;
      default:     cap_bytes = `FSP_CAP_8K_LAST;
    endcase
  endfunction

  // capacity trims the address space; 8 KB covers all 13 bits
  assign in_range = (cap == `FSP_CAP_2K || cap == `FSP_CAP_4K) ?
                    fadr < cap_bytes(cap) : 1'b1;
  // one protect bit guards each eighth of the selected capacity
  function automatic logic [2:0] prot_idx(input logic [12:0] a,
                                           input logic [1:0]  c);
    unique case (c)
      `FSP_CAP_2K: prot_idx = a[10:8];
      `FSP_CAP_4K: prot_idx = a[11:9];
      default:     prot_idx = a[12:10];
    endcase
  endfunction
  assign allowed = !prot[prot_idx(fadr, cap)];
  assign cmd_wr  = wr && addr == `FSP_ADDR_CMD;
  assign op_ok   = self_mode && !busy && in_range && allowed;

  always_ff @(posedge clk) begin
    if (rst) begin
      op <= '0;
    end else begin
      op.go    <= cmd_wr && op_ok &&
                  (wdata == `FSP_CMD_WRITE || wdata == `FSP_CMD_ERASE);
      op.erase <= wdata == `FSP_CMD_ERASE;
      op.addr  <= fadr;
      op.data  <= fdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cmd   <= `FSP_CMD_NONE;
      prot  <= `FSP_RESET_BYTE;
      fadr  <= '0;
      fdata <= `FSP_RESET_BYTE;
      cap   <= `FSP_CAP_8K;
    end else if (wr) begin
      unique case (addr)
        `FSP_ADDR_CMD:  cmd   <= wdata;
        `FSP_ADDR_PROT: prot  <= wdata;
        `FSP_ADDR_ADRL: fadr  <= {fadr[12:8], wdata};
        `FSP_ADDR_ADRH: fadr  <= {wdata[4:0], fadr[7:0]};
        `FSP_ADDR_DATA: fdata <= wdata;
        `FSP_ADDR_CFG:  cap   <= wdata[1:0];
        default: ;
      endcase
    end
  end

  // hardware sets win over a clearing write in the same cycle
  logic rej;
  assign rej = cmd_wr && wdata != `FSP_CMD_NONE && !op_ok;
  logic st_clr;
  assign st_clr = wr && addr == `FSP_ADDR_STATUS;
  always_ff @(posedge clk) begin
    if (rst) begin
      st_seqerr  <= 1'b0;
      st_proterr <= 1'b0;
      st_done    <= 1'b0;
    end else begin
      st_seqerr  <= seq_err  || (st_seqerr  && !st_clr);
      st_proterr <= rej      || (st_proterr && !st_clr);
      st_done    <= seq_done || (st_done    && !st_clr);
    end
  end

  assign ev = {seq_done, rej, seq_err};
  always_ff @(posedge clk) begin
    if (rst) begin
      istat <= '0;
      imask <= '0;
    end else begin
      istat <= ev | (istat & ~((wr && addr == `FSP_ADDR_ISTAT) ?
                               wdata[2:0] : 3'h0));
      if (wr && addr == `FSP_ADDR_IMASK) begin
        imask <= wdata[2:0];
      end
    end
  end
  assign irq = |(istat & imask);

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= '0;
    end else if (rd) begin
      unique case (addr)
        `FSP_ADDR_CMD:    rdata <= cmd;
        `FSP_ADDR_STATUS: rdata <= {5'h00, st_done, st_proterr,
                                    st_seqerr};
        `FSP_ADDR_MODE:   rdata <= self_mode ? `FSP_MODE_SELF
                                             : `FSP_MODE_NORMAL;
        `FSP_ADDR_PROT:   rdata <= prot;
        `FSP_ADDR_ADRL:   rdata <= fadr[7:0];
        `FSP_ADDR_ADRH:   rdata <= {3'h0, fadr[12:8]};
        `FSP_ADDR_DATA:   rdata <= fdata;
        `FSP_ADDR_CFG:    rdata <= {6'h00, cap};
        `FSP_ADDR_IMASK:  rdata <= {5'h00, imask};
        `FSP_ADDR_ISTAT:  rdata <= {5'h00, istat};
        `FSP_ADDR_RDDATA: rdata <= arr_data;
        default:          rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end

  property p_prot_reject;
    @(posedge clk) disable iff (rst)
      cmd_wr && wdata == `FSP_CMD_WRITE && !allowed |=> !op.go && st_proterr;
  endproperty
  a_prot_reject: assert property (p_prot_reject)
    else $error("protected block operation not rejected");

  property p_seqerr_flag;
    @(posedge clk) disable iff (rst) seq_err |=> st_seqerr;
  endproperty
  a_seqerr_flag: assert property (p_seqerr_flag)
    else $error("sequence error flag not set");

  // an unmasked event must show on the pin one cycle later
  property p_irq;
    @(posedge clk) disable iff (rst) |(ev & imask) |=> irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("irq does not follow status and mask");

  c_erase: cover property (@(posedge clk) disable iff (rst)
                           op.go && op.erase);
  c_write: cover property (@(posedge clk) disable iff (rst)
                           op.go && !op.erase);
  c_irq: cover property (@(posedge clk) disable iff (rst) irq);

  // helper count of busy cycles; a long repetition would slow the tools
  logic [8:0] busy_cnt;
  always_ff @(posedge clk) begin
    if (rst || !busy) begin
      busy_cnt <= '0;
    end else begin
      busy_cnt <= busy_cnt + 9'h001;
    end
  end

  // erase timing and start
  property p_erase_len;
    @(posedge clk) disable iff (rst)
      $fell(busy) |-> busy_cnt == `FSP_ERASE_CYCLES;
  endproperty
  a_erase_len: assert property (p_erase_len)
    else $error("erase did not cover one whole block");

  property p_erase_start;
    @(posedge clk) disable iff (rst)
      op.go && op.erase && !busy |=> busy;
  endproperty
  a_erase_start: assert property (p_erase_start)
    else $error("accepted erase did not start");

  property p_busy_reject;
    @(posedge clk) disable iff (rst)
      cmd_wr && busy |=> !op.go;
  endproperty
  a_busy_reject: assert property (p_busy_reject)
    else $error("command accepted while erasing");

  property p_write_idle;
    @(posedge clk) disable iff (rst)
      op.go |-> !busy;
  endproperty
  a_write_idle: assert property (p_write_idle)
    else $error("operation issued while array busy");

  // acceptance only in self programming mode
  property p_mode_reject;
    @(posedge clk) disable iff (rst)
      cmd_wr && !self_mode |=> !op.go;
  endproperty
  a_mode_reject: assert property (p_mode_reject)
    else $error("operation accepted in normal mode");

  property p_range_reject;
    @(posedge clk) disable iff (rst)
      cmd_wr && wdata == `FSP_CMD_WRITE && !in_range
      |=> !op.go && st_proterr;
  endproperty
  a_range_reject: assert property (p_range_reject)
    else $error("out of range write not rejected");

  property p_cap_write;
    @(posedge clk) disable iff (rst)
      wr && addr == `FSP_ADDR_CFG |=> cap == $past(wdata[1:0]);
  endproperty
  a_cap_write: assert property (p_cap_write)
    else $error("capacity select not stored");

  property p_prot_erase;
    @(posedge clk) disable iff (rst)
      cmd_wr && wdata == `FSP_CMD_ERASE && !allowed
      |=> !op.go && st_proterr;
  endproperty
  a_prot_erase: assert property (p_prot_erase)
    else $error("protected block erase not rejected");

  property p_go_ok;
    @(posedge clk) disable iff (rst)
      op.go |-> $past(op_ok);
  endproperty
  a_go_ok: assert property (p_go_ok)
    else $error("operation issued without permission");

  // status and interrupt flags
  property p_status_clear;
    @(posedge clk) disable iff (rst)
      st_clr && !seq_err && !rej && !seq_done
      |=> !st_seqerr && !st_proterr && !st_done;
  endproperty
  a_status_clear: assert property (p_status_clear)
    else $error("status write did not clear flags");

  property p_done_flag;
    @(posedge clk) disable iff (rst)
      seq_done |=> st_done && istat[`FSP_IRQ_DONE];
  endproperty
  a_done_flag: assert property (p_done_flag)
    else $error("sequence done not recorded");

  property p_seqerr_irq;
    @(posedge clk) disable iff (rst)
      seq_err |=> istat[`FSP_IRQ_SEQERR];
  endproperty
  a_seqerr_irq: assert property (p_seqerr_irq)
    else $error("sequence error not latched for interrupt");

  property p_istat_clear;
    @(posedge clk) disable iff (rst)
      wr && addr == `FSP_ADDR_ISTAT && wdata[2:0] == 3'h7 && ev == 3'h0
      |=> istat == 3'h0;
  endproperty
  a_istat_clear: assert property (p_istat_clear)
    else $error("interrupt status not cleared");

  // read port: data only in the cycle after the strobe
  property p_rdata_idle;
    @(posedge clk) disable iff (rst)
      !rd |=> rdata == `FSP_RESET_BYTE;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside read cycle");

  property p_status_read;
    @(posedge clk) disable iff (rst)
      rd && addr == `FSP_ADDR_STATUS
      |=> rdata[`FSP_ST_SEQERR] == $past(st_seqerr);
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status read lost the sequence error bit");

  property p_mode_read;
    @(posedge clk) disable iff (rst)
      rd && addr == `FSP_ADDR_MODE
      |=> rdata == ($past(self_mode) ? `FSP_MODE_SELF : `FSP_MODE_NORMAL);
  endproperty
  a_mode_read: assert property (p_mode_read)
    else $error("mode read does not match mode");
endmodule

// ### test_fsp_top.sv
`timescale 1ns/10ps
`include "fsp_regs.svh"
module test_fsp_top
  import fsp_pkg::*;
;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic       irq;
  logic       self_mode;
  int         mismatches = 0;
  int         samples_checked = 0;
  int         cycles = 0;
  logic [7:0] v;
  logic [7:0] bad_key [2] = '{8'h5A, 8'hA5};
  logic [7:0] bad_inv [2] = '{8'hFF, 8'hFE};

  always #5 clk = ~clk;

  fsp_top dut (
    .clk       (clk),
    .rst       (rst),
    .addr      (addr),
    .wdata     (wdata),
    .wr        (wr),
    .rd        (rd),
    .rdata     (rdata),
    .irq       (irq),
    .self_mode (self_mode)
  );

  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ceiling well above the ~2700 cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      $display("CHECK FAILED at %0t: run hung", $time);
      summarize;
    end
  end

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: pin %b expected %b", $time, got, exp);
    end
  endtask

  // idle edge after each strobe so no signal is driven twice in one step
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk_byte(rdata, exp);
    @(posedge clk);
  endtask

  task automatic set_adr(input logic [12:0] a);
    wr_reg(`FSP_ADDR_ADRL, a[7:0]);
    wr_reg(`FSP_ADDR_ADRH, {3'b000, a[12:8]});
  endtask

  // no completion flag on the port, so wait past the 256-cycle erase
  task automatic flash_op(input logic [12:0] a, input logic [7:0] c,
                          input logic [7:0] d);
    set_adr(a);
    wr_reg(`FSP_ADDR_DATA, d);
    wr_reg(`FSP_ADDR_CMD, c);
    repeat (300) @(posedge clk);
  endtask

  task automatic flash_rd(input logic [12:0] a, input logic [7:0] exp);
    set_adr(a);
    repeat (2) @(posedge clk);
    rd_reg(`FSP_ADDR_RDDATA, exp);
  endtask

  task automatic mode_seq(input logic [7:0] k, input logic [7:0] v1,
                          input logic [7:0] v2, input logic [7:0] v3);
    wr_reg(`FSP_ADDR_KEY, k);
    wr_reg(`FSP_ADDR_MODE, v1);
    wr_reg(`FSP_ADDR_MODE, v2);
    wr_reg(`FSP_ADDR_MODE, v3);
  endtask

  function automatic logic seq_ok(input logic [7:0] k, input logic [7:0] v1,
                                  input logic [7:0] v2, input logic [7:0] v3);
    return k == `FSP_KEY_VALUE && v2 == ~v1 && v3 == v1;
  endfunction

  initial begin
    v = $urandom(32'h876db0eb);
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk_bit(self_mode, 1'b1);
    chk_bit(irq, 1'b0);
    rd_reg(`FSP_ADDR_STATUS, 8'h00);
    rd_reg(`FSP_ADDR_MODE, `FSP_MODE_SELF);
    rd_reg(8'h3C, 8'h00);
    wr_reg(`FSP_ADDR_CFG, {6'h00, `FSP_CAP_8K});
    flash_op(13'h0345, `FSP_CMD_ERASE, 8'h00);
    flash_op(13'h0400, `FSP_CMD_ERASE, 8'h00);
    flash_rd(13'h0345, `FSP_ERASED_BYTE);
    flash_op(13'h0345, `FSP_CMD_WRITE, 8'h5C);
    flash_op(13'h0400, `FSP_CMD_WRITE, 8'hA7);
    flash_rd(13'h0345, 8'h5C);
    flash_rd(13'h0346, `FSP_ERASED_BYTE);
    flash_op(13'h03FF, `FSP_CMD_ERASE, 8'h00);
    flash_rd(13'h0345, `FSP_ERASED_BYTE);
    flash_rd(13'h0400, 8'hA7);
    rd_reg(`FSP_ADDR_STATUS, 8'h00);
    wr_reg(`FSP_ADDR_PROT, 8'h02);
    flash_op(13'h0400, `FSP_CMD_ERASE, 8'h00);
    flash_rd(13'h0400, 8'hA7);
    rd_reg(`FSP_ADDR_STATUS, 8'h02);
    wr_reg(`FSP_ADDR_STATUS, 8'h00);
    wr_reg(`FSP_ADDR_PROT, 8'h00);
    for (int c = 0; c < 2; c++) begin
      wr_reg(`FSP_ADDR_CFG, 8'(c));
      flash_op(13'(2048 << c), `FSP_CMD_WRITE, 8'h00);
      rd_reg(`FSP_ADDR_STATUS, 8'h02);
      wr_reg(`FSP_ADDR_STATUS, 8'h00);
    end
    rd_reg(`FSP_ADDR_ISTAT, 8'h02);
    chk_bit(irq, 1'b0);
    wr_reg(`FSP_ADDR_IMASK, 8'h02);
    chk_bit(irq, 1'b1);
    wr_reg(`FSP_ADDR_ISTAT, 8'h02);
    chk_bit(irq, 1'b0);
    wr_reg(`FSP_ADDR_CMD, `FSP_CMD_NONE);
    for (int i = 0; i < 3; i++) begin
      wr_reg(`FSP_ADDR_STATUS, 8'h00);
      if (i < 2)
        mode_seq(bad_key[i], 8'h00, bad_inv[i], 8'h00);
      else
        mode_seq(8'hA5, v, ~v ^ 8'h10, v);
      chk_bit(self_mode, 1'b1);
      rd_reg(`FSP_ADDR_STATUS, 8'h01);
    end
    wr_reg(`FSP_ADDR_STATUS, 8'h00);
    wr_reg(`FSP_ADDR_KEY, `FSP_KEY_VALUE);
    wr_reg(`FSP_ADDR_MODE, 8'h00);
    wr_reg(`FSP_ADDR_CMD, 8'h00);
    wr_reg(`FSP_ADDR_MODE, 8'hFF);
    wr_reg(`FSP_ADDR_MODE, 8'h00);
    chk_bit(self_mode, 1'b1);
    rd_reg(`FSP_ADDR_STATUS, 8'h01);
    wr_reg(`FSP_ADDR_STATUS, 8'h00);
    wr_reg(`FSP_ADDR_KEY, `FSP_KEY_VALUE);
    wr_reg(`FSP_ADDR_MODE, 8'h00);
    chk_bit(self_mode, 1'b1);
    wr_reg(`FSP_ADDR_MODE, 8'hFF);
    chk_bit(self_mode, 1'b1);
    wr_reg(`FSP_ADDR_MODE, 8'h00);
    chk_bit(self_mode, 1'b0);
    rd_reg(`FSP_ADDR_MODE, `FSP_MODE_NORMAL);
    rd_reg(`FSP_ADDR_STATUS, 8'h04);
    chk_bit(irq, 1'b0);
    wr_reg(`FSP_ADDR_IMASK, 8'h04);
    chk_bit(irq, 1'b1);
    wr_reg(`FSP_ADDR_ISTAT, 8'h04);
    chk_bit(irq, 1'b0);
    // random targets; a zero target must land in normal mode
    repeat (5) begin
      v = $urandom;
      wr_reg(`FSP_ADDR_STATUS, 8'h00);
      mode_seq(`FSP_KEY_VALUE, v, ~v, v);
      chk_bit(self_mode, seq_ok(`FSP_KEY_VALUE, v, ~v, v) && v != 0);
      rd_reg(`FSP_ADDR_STATUS, 8'h04);
    end
    summarize;
  end
endmodule
